// ==== hdl/sfpc_defines.svh ====
`ifndef SFPC_DEFINES_SVH
`define SFPC_DEFINES_SVH

// ----------------------------------------------------------------------
// Reset values and transmit idle fill byte
// ----------------------------------------------------------------------
`define SFPC_STATUS_RST   6'h00
`define SFPC_SYNC_RST     7'h01
`define SFPC_IDLE_FILL    8'hFF

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define SFPC_BYTE_BITS    4'h8
`define SFPC_PIN_BITS     7
`define SFPC_IO_SI        0
`define SFPC_IO_SO        1
`define SFPC_IO_WP        2
`define SFPC_IO_SHARED    3

// ----------------------------------------------------------------------
// Output enable masks and steps per line width
// ----------------------------------------------------------------------
`define SFPC_OE_SINGLE    4'h2
`define SFPC_OE_DUAL      4'h3
`define SFPC_OE_QUAD      4'hF
`define SFPC_STEP_SINGLE  4'h1
`define SFPC_STEP_DUAL    4'h2
`define SFPC_STEP_QUAD    4'h4

// ----------------------------------------------------------------------
// Buffering
// ----------------------------------------------------------------------
`define SFPC_FIFO_DEPTH   16

`endif

// ==== hdl/sfpc_pkg.sv ====
package sfpc_pkg;

    // ------------------------------------------------------------------
    // Line width of the current transfer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SFPC_W_SINGLE = 2'h0,
        SFPC_W_DUAL   = 2'h1,
        SFPC_W_QUAD   = 2'h2
    } sfpc_width_e;

    // ------------------------------------------------------------------
    // Link state, Gray along idle, selected, paused
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SFPC_ST_IDLE  = 2'h0,
        SFPC_ST_SEL   = 2'h1,
        SFPC_ST_HOLD  = 2'h3,
        SFPC_ST_RST   = 2'h2
    } sfpc_state_e;

    // ------------------------------------------------------------------
    // Protectable status bits
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       status_lock_bit;
        logic       quad_io_enable;
        logic [3:0] block_protect_bits;
    } sfpc_status_s;

    // ------------------------------------------------------------------
    // Sampled pin group
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
        logic       rst_n;
    } sfpc_pins_s;

endpackage : sfpc_pkg

// ==== hdl/sfpc_mem.sv ====
`timescale 1ns/100ps

module sfpc_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
    input  wire logic [W-1:0]             i_wr_data,
    input  wire logic                     i_rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
    output logic      [W-1:0]             o_rd_data
);

    logic [W-1:0] mem_r [DEPTH];

    // Array write
    always_ff @(posedge i_ref_clk) begin
        if (i_wr_en) begin
            mem_r[i_wr_addr] <= i_wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= mem_r[i_rd_addr];
        end
    end

endmodule : sfpc_mem

// ==== hdl/sfpc_fifo.sv ====
`timescale 1ns/100ps

module sfpc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic      [W-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);

    // Elaboration check
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
        $error("sfpc_fifo: DEPTH must be a power of two >= 2");
    end

    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   cnt_r;
    logic          out_valid_r;
    logic          push;
    logic          fetch;

    // Handshakes
    assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign push        = i_in_valid && o_in_ready;
    assign fetch       = (cnt_r != '0) && (!out_valid_r || i_out_ready);
    assign o_out_valid = out_valid_r;

    // Pointers and fill level
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (fetch) rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !fetch) cnt_r <= cnt_r + 1'b1;
            else if (fetch && !push) cnt_r <= cnt_r - 1'b1;
        end
    end

    // Output slot
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            out_valid_r <= 1'b0;
        end else if (fetch) begin
            out_valid_r <= 1'b1;
        end else if (i_out_ready) begin
            out_valid_r <= 1'b0;
        end
    end

    sfpc_mem #(
        .W     (W),
        .DEPTH (DEPTH)
    ) u_mem (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_wr_en   (push),
        .i_wr_addr (wr_ptr_r),
        .i_wr_data (i_in_data),
        .i_rd_en   (fetch),
        .i_rd_addr (rd_ptr_r),
        .o_rd_data (o_out_data)
    );

endmodule : sfpc_fifo

// ==== hdl/sfpc_core.sv ====
`timescale 1ns/100ps
`include "sfpc_defines.svh"

// Functional notes
// - Deselected: outputs off, standby indicated
// - Pin data ignored while deselected
// - No instruction before first select falling edge
// - Single mode samples input on rising clock
// - Single mode drives output on falling clock
// - Dual/quad reuse data pins bidirectionally
// - Lock plus low protect rejects status writes unless quad enabled
// - Lock clear permits status writes always
// - Quad enable turns protect pin into data
// - Quad enable turns shared pin into data
// - No dedicated reset: select bit chooses function
// - Dedicated reset enabled: shared pin pauses only
// - Dedicated reset disabled: select bit chooses
// - Pause holds sequence, outputs off, resumes
// - Reset low holds reset, outputs off
// - Function bit one disables dedicated reset
// - Both clock idle polarities accepted
module sfpc_core #(
    parameter int HAS_DEDIC_RST = 1,
    parameter int RST_PIN_WIRED = 1,
    parameter int FIFO_DEPTH    = `SFPC_FIFO_DEPTH
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_sck,
    input  wire logic [3:0]           i_io_in,
    input  wire logic                 i_rst_pin_n,
    output logic      [3:0]           o_io_out,
    output logic      [3:0]           o_io_oe,
    input  wire sfpc_pkg::sfpc_width_e i_xfer_width,
    input  wire logic                 i_drive_out,
    input  wire logic                 i_hold_reset_select,
    input  wire logic                 i_func_rst_disable,
    input  wire logic                 i_sr_wr_valid,
    input  wire sfpc_pkg::sfpc_status_s i_sr_wr_data,
    output logic                      o_sr_wr_reject,
    output sfpc_pkg::sfpc_status_s    o_status,
    input  wire logic [7:0]           i_tx_data,
    input  wire logic                 i_tx_valid,
    output logic                      o_tx_ready,
    output logic      [7:0]           o_rx_data,
    output logic                      o_rx_valid,
    input  wire logic                 i_rx_ready,
    output logic                      o_rx_overflow,
    output logic                      o_selected,
    output logic                      o_paused,
    output logic                      o_in_reset,
    output logic                      o_standby
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (FIFO_DEPTH < 2) begin : g_bad
        $error("sfpc_core: FIFO_DEPTH must be at least 2");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [`SFPC_PIN_BITS-1:0] pin_raw;
    logic [`SFPC_PIN_BITS-1:0] pin_sync;
    sfpc_pkg::sfpc_pins_s      pins;

    // Unwired dedicated reset reads high
    assign pin_raw = {i_cs_n, i_sck, i_io_in,
                      (RST_PIN_WIRED != 0) ? i_rst_pin_n : 1'b1};

    genvar gi;
    for (gi = 0; gi < `SFPC_PIN_BITS; gi++) begin : g_sync
        logic s1_r;
        logic s2_r;
        // Two stages per pin
        always_ff @(posedge i_ref_clk) begin
            if (i_rst) begin
                s1_r <= 1'(`SFPC_SYNC_RST >> gi);
                s2_r <= 1'(`SFPC_SYNC_RST >> gi);
            end else begin
                s1_r <= pin_raw[gi];
                s2_r <= s1_r;
            end
        end
        assign pin_sync[gi] = s2_r;
    end
    assign pins = sfpc_pkg::sfpc_pins_s'(pin_sync);

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    logic cs_prev_r;
    logic sck_prev_r;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;

    // Previous samples; select resets low so power-up needs a high first
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cs_prev_r  <= 1'b0;
            sck_prev_r <= 1'b0;
        end else begin
            cs_prev_r  <= pins.cs_n;
            sck_prev_r <= pins.sck;
        end
    end
    assign cs_fall  = cs_prev_r && !pins.cs_n;
    assign sck_rise = !sck_prev_r && pins.sck;
    assign sck_fall = sck_prev_r && !pins.sck;

    // ------------------------------------------------------------------
    // Shared pin function and reset sources
    // ------------------------------------------------------------------
    sfpc_pkg::sfpc_status_s status_r;
    logic dedic_en;
    logic shared_is_rst;
    logic shared_is_hold;
    logic hw_rst;
    logic hold_req;
    logic wp_active;

    assign dedic_en = (HAS_DEDIC_RST != 0) && !i_func_rst_disable;
    // Shared pin role from quad enable, select bit and dedicated reset
    assign shared_is_rst  = !status_r.quad_io_enable && !dedic_en
                            && i_hold_reset_select;
    assign shared_is_hold = !status_r.quad_io_enable
                            && !shared_is_rst;
    assign hw_rst   = (dedic_en && !pins.rst_n)
                      || (shared_is_rst && !pins.io[`SFPC_IO_SHARED]);
    assign hold_req = shared_is_hold && !pins.io[`SFPC_IO_SHARED];
    assign wp_active = !status_r.quad_io_enable;

    // ------------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------------
    sfpc_pkg::sfpc_state_e state_r;
    sfpc_pkg::sfpc_state_e state_nxt;

    // Next state, reset first, then deselect, then pause
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sfpc_pkg::SFPC_ST_IDLE: begin
                if (hw_rst) state_nxt = sfpc_pkg::SFPC_ST_RST;
                else if (cs_fall) state_nxt = sfpc_pkg::SFPC_ST_SEL;
            end
            sfpc_pkg::SFPC_ST_SEL: begin
                if (hw_rst) state_nxt = sfpc_pkg::SFPC_ST_RST;
                else if (pins.cs_n) state_nxt = sfpc_pkg::SFPC_ST_IDLE;
                else if (hold_req) state_nxt = sfpc_pkg::SFPC_ST_HOLD;
            end
            sfpc_pkg::SFPC_ST_HOLD: begin
                if (hw_rst) state_nxt = sfpc_pkg::SFPC_ST_RST;
                else if (pins.cs_n) state_nxt = sfpc_pkg::SFPC_ST_IDLE;
                else if (!hold_req) state_nxt = sfpc_pkg::SFPC_ST_SEL;
            end
            default: begin
                if (!hw_rst) state_nxt = sfpc_pkg::SFPC_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) state_r <= sfpc_pkg::SFPC_ST_IDLE;
        else state_r <= state_nxt;
    end

    assign o_selected = (state_r == sfpc_pkg::SFPC_ST_SEL);
    assign o_paused   = (state_r == sfpc_pkg::SFPC_ST_HOLD);
    assign o_in_reset = (state_r == sfpc_pkg::SFPC_ST_RST);
    assign o_standby  = (state_r == sfpc_pkg::SFPC_ST_IDLE);

    // ------------------------------------------------------------------
    // Width decode
    // ------------------------------------------------------------------
    logic [3:0] step;
    logic [3:0] oe_mask;

    // Quad needs quad enable, otherwise falls back to single line
    always_comb begin
        step    = `SFPC_STEP_SINGLE;
        oe_mask = `SFPC_OE_SINGLE;
        if (i_xfer_width == sfpc_pkg::SFPC_W_DUAL) begin
            step    = `SFPC_STEP_DUAL;
            oe_mask = `SFPC_OE_DUAL;
        end else if (i_xfer_width == sfpc_pkg::SFPC_W_QUAD
                     && status_r.quad_io_enable) begin
            step    = `SFPC_STEP_QUAD;
            oe_mask = `SFPC_OE_QUAD;
        end
    end

    // ------------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------------
    logic [7:0] rx_sh_r;
    logic [7:0] rx_sh_nxt;
    logic [3:0] rx_cnt_r;
    logic [3:0] rx_sum;
    logic       rx_take;
    logic       push_r;
    logic [7:0] push_data_r;
    logic       fifo_ready;

    assign rx_take = o_selected && sck_rise && !i_drive_out;
    assign rx_sum  = rx_cnt_r + step;

    // Shift in one, two or four lines, io0 lowest
    always_comb begin
        case (step)
            `SFPC_STEP_DUAL: rx_sh_nxt = {rx_sh_r[5:0], pins.io[1:0]};
            `SFPC_STEP_QUAD: rx_sh_nxt = {rx_sh_r[3:0], pins.io};
            default:         rx_sh_nxt = {rx_sh_r[6:0], pins.io[0]};
        endcase
    end

    // Bit counting; kept through pause, cleared on deselect or reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || o_standby || o_in_reset) begin
            rx_sh_r  <= '0;
            rx_cnt_r <= '0;
        end else if (rx_take) begin
            rx_sh_r  <= rx_sh_nxt;
            rx_cnt_r <= (rx_sum >= `SFPC_BYTE_BITS) ? 4'h0 : rx_sum;
        end
    end

    // Completed byte toward the buffer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            push_r        <= 1'b0;
            push_data_r   <= '0;
            o_rx_overflow <= 1'b0;
        end else begin
            push_r        <= rx_take && (rx_sum >= `SFPC_BYTE_BITS);
            o_rx_overflow <= push_r && !fifo_ready;
            if (rx_take) push_data_r <= rx_sh_nxt;
        end
    end

    sfpc_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_in_valid  (push_r),
        .o_in_ready  (fifo_ready),
        .i_in_data   (push_data_r),
        .o_out_valid (o_rx_valid),
        .i_out_ready (i_rx_ready),
        .o_out_data  (o_rx_data)
    );

    // ------------------------------------------------------------------
    // Transmit shifter and pin drive
    // ------------------------------------------------------------------
    logic [7:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic [3:0] tx_sum;
    logic [7:0] tx_byte;
    logic       tx_step;

    assign tx_step    = o_selected && sck_fall && i_drive_out;
    assign o_tx_ready = tx_step && (tx_cnt_r == 4'h0);
    assign tx_byte    = (tx_cnt_r != 4'h0) ? tx_sh_r
                        : (i_tx_valid ? i_tx_data : `SFPC_IDLE_FILL);
    assign tx_sum     = tx_cnt_r + step;

    // Byte progress on falling edges
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || o_standby || o_in_reset) begin
            tx_sh_r  <= '0;
            tx_cnt_r <= '0;
        end else if (tx_step) begin
            tx_sh_r  <= tx_byte << step;
            tx_cnt_r <= (tx_sum >= `SFPC_BYTE_BITS) ? 4'h0 : tx_sum;
        end
    end

    // Output lines, most significant bit first
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_io_out <= '0;
        end else if (tx_step) begin
            case (step)
                `SFPC_STEP_DUAL: o_io_out <= {2'b00, tx_byte[7:6]};
                `SFPC_STEP_QUAD: o_io_out <= tx_byte[7:4];
                default:         o_io_out <= {2'b00, tx_byte[7], 1'b0};
            endcase
        end
    end

    // Enables only while selected, unpaused and driving
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_io_oe <= '0;
        end else if (state_nxt == sfpc_pkg::SFPC_ST_SEL && i_drive_out) begin
            o_io_oe <= oe_mask;
        end else begin
            o_io_oe <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Status bits with protect pin
    // ------------------------------------------------------------------
    logic sr_locked;

    assign sr_locked = status_r.status_lock_bit && wp_active
                       && !pins.io[`SFPC_IO_WP];

    // Write or reject
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            status_r       <= `SFPC_STATUS_RST;
            o_sr_wr_reject <= 1'b0;
        end else begin
            o_sr_wr_reject <= i_sr_wr_valid && sr_locked;
            if (i_sr_wr_valid && !sr_locked) begin
                status_r <= i_sr_wr_data;
            end
        end
    end
    assign o_status = status_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_standby_hiz: assert property (
        o_standby |-> o_io_oe == 4'h0)
        else $error("outputs driven while deselected");
    a_deselect_ignore: assert property (
        o_standby |=> !push_r && rx_cnt_r == 4'h0)
        else $error("data accepted while deselected");
    a_select_edge: assert property (
        o_standby ##1 o_selected |-> $past(cs_fall))
        else $error("selected without a select falling edge");
    a_rise_sample: assert property (
        rx_take && step == `SFPC_STEP_SINGLE && rx_cnt_r == 4'h7
        |=> push_r && push_data_r[0] == $past(pins.io[0]))
        else $error("byte not completed on eighth rising edge");
    a_fall_drive: assert property (
        tx_step && step == `SFPC_STEP_SINGLE
        |=> o_io_out[1] == $past(tx_byte[7]))
        else $error("serial output not updated on falling edge");
    a_quad_pins: assert property (
        o_io_oe[3] |-> $past(status_r.quad_io_enable))
        else $error("upper lines driven without quad enable");
    a_lock_reject: assert property (
        i_sr_wr_valid && sr_locked |=> o_sr_wr_reject && $stable(o_status))
        else $error("protected status write not rejected");
    a_unlock_write: assert property (
        i_sr_wr_valid && !status_r.status_lock_bit
        |=> o_status == $past(i_sr_wr_data) && !o_sr_wr_reject)
        else $error("unlocked status write lost");
    a_quad_no_pause: assert property (
        status_r.quad_io_enable && o_selected && !hw_rst |=> !o_paused)
        else $error("pause taken while shared pin is data");
    a_pause_hold: assert property (
        o_paused ##1 o_paused |-> o_io_oe == 4'h0 && $stable(rx_cnt_r))
        else $error("pause did not freeze the link");
    a_reset_hiz: assert property (
        hw_rst |=> o_in_reset ##1 o_io_oe == 4'h0)
        else $error("hardware reset not honoured");
    a_dedic_off: assert property (
        i_func_rst_disable && !shared_is_rst |-> !hw_rst)
        else $error("disabled dedicated reset still acts");

    c_byte_in:  cover property (push_r && fifo_ready);
    c_pause:    cover property (o_paused ##1 o_selected);
    c_rejected: cover property (o_sr_wr_reject);
    c_quad_out: cover property (o_io_oe == `SFPC_OE_QUAD);

endmodule : sfpc_core

// ==== test/sfpc_host.sv ====
`timescale 1ns/100ps

module sfpc_host (
    output logic       o_cs_n,
    output logic       o_sck,
    output logic [3:0] o_io
);
    // Clock idles high when set (mode 3)
    logic idle_hi = 1'b0;
    // Parked: deselected, clock low, protect and pause high
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_io   = 4'hC;
    end
    // Byte MSB first on io0, rising edge samples, mode 0 or 3
    task automatic send_byte(input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            o_sck   = 1'b0;
            o_io[0] = b[k];
            #80 o_sck = 1'b1;
            #80;
        end
        if (!idle_hi) o_sck = 1'b0;
        o_io[0] = ~b[0];
    endtask : send_byte
    // Whole frame: select fall, byte, deselect
    task automatic frame(input logic [7:0] b);
        o_cs_n = 1'b0;
        #160 send_byte(b);
        #160 o_cs_n = 1'b1;
        #160;
    endtask : frame
endmodule : sfpc_host

// ==== test/sfpc_core_tb_top.sv ====
`timescale 1ns/100ps

module sfpc_core_tb_top;
    logic                  i_ref_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  drv = 1'b0;
    logic                  frd = 1'b0;
    logic                  rpin_n = 1'b1;
    logic                  sr_v = 1'b0;
    sfpc_pkg::sfpc_status_s sr_d = '0;
    logic                  rdy = 1'b0;
    logic                  cs_n, sck, rej, rv, ov, rej_s, ov_s, trdy, tr_s;
    logic                  hsel = 1'b0;
    sfpc_pkg::sfpc_width_e wid = sfpc_pkg::SFPC_W_SINGLE;
    logic [3:0]            h_io, io_o, oe, io_w;
    logic [7:0]            rd;
    sfpc_pkg::sfpc_status_s st;
    logic                  sel, pau, inr, stb;
    int                    mismatches = 0;
    int                    checks_done = 0;

    always #5 i_ref_clk = ~i_ref_clk;
    assign io_w = (oe & io_o) | (~oe & h_io);
    // Sticky capture of one-cycle pulses
    always @(posedge i_ref_clk) begin
        rej_s <= rst ? 1'b0 : (rej_s | rej);
        ov_s  <= rst ? 1'b0 : (ov_s | ov);
        tr_s  <= rst ? 1'b0 : (tr_s | trdy);
    end

    sfpc_host i_host (.o_cs_n(cs_n), .o_sck(sck), .o_io(h_io));
    sfpc_core i_dut (.i_ref_clk(i_ref_clk), .i_rst(rst), .i_cs_n(cs_n),
        .i_sck(sck), .i_io_in(io_w), .i_rst_pin_n(rpin_n),
        .o_io_out(io_o), .o_io_oe(oe), .i_xfer_width(wid),
        .i_drive_out(drv), .i_hold_reset_select(hsel),
        .i_func_rst_disable(frd), .i_sr_wr_valid(sr_v), .i_sr_wr_data(sr_d),
        .o_sr_wr_reject(rej), .o_status(st), .i_tx_data(8'h3C),
        .i_tx_valid(1'b1), .o_tx_ready(trdy), .o_rx_data(rd), .o_rx_valid(rv),
        .i_rx_ready(rdy), .o_rx_overflow(ov), .o_selected(sel),
        .o_paused(pau), .o_in_reset(inr), .o_standby(stb));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : cyc
    // Mode 0 read: one falling edge per bit, io1 sampled mid-low
    task automatic rd_byte(input logic [7:0] exp);
        logic [7:0] b;
        for (int k = 7; k >= 0; k--) begin
            #80 i_host.o_sck = 1'b1;
            #80 i_host.o_sck = 1'b0;
            #80 b[k] = io_w[1];
        end
        check(b, exp);
    endtask : rd_byte
    // Take one byte from the receive buffer
    task automatic pop;
        rdy = 1'b1;
        cyc(1);
        rdy = 1'b0;
    endtask : pop
    task automatic wr_sr(input logic [5:0] d, input logic io2);
        i_host.o_io[2] = io2;
        cyc(5);
        sr_v = 1'b1;
        sr_d = d;
        cyc(1);
        sr_v = 1'b0;
        cyc(3);
    endtask : wr_sr
    task automatic print_verdict;
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial begin
        #200000 mismatches++;
        print_verdict();
    end

    initial begin
        cyc(16);
        rst = 1'b0;
        cyc(4);
        check(stb, 1'b1);
        check(oe, 4'h0);
        check(st, 6'h00);
        i_host.send_byte(8'h5A);
        cyc(5);
        check(rv, 1'b0);
        i_host.frame(8'hA5);
        check(rv, 1'b1);
        check(rd, 8'hA5);
        pop();
        i_host.idle_hi = 1'b1;
        i_host.o_sck = 1'b1;
        cyc(4);
        i_host.frame(8'hC3);
        check(rd, 8'hC3);
        pop();
        i_host.idle_hi = 1'b0;
        i_host.o_sck = 1'b0;
        wr_sr(6'h25, 1'b1);
        check(st, 6'h25);
        wr_sr(6'h23, 1'b0);
        check(st, 6'h25);
        check(rej_s, 1'b1);
        wr_sr(6'h03, 1'b1);
        check(st, 6'h03);
        wr_sr(6'h01, 1'b0);
        check(st, 6'h01);
        wr_sr(6'h30, 1'b0);
        check(st, 6'h30);
        wr_sr(6'h31, 1'b0);
        check(st, 6'h31);
        i_host.o_cs_n = 1'b0;
        drv = 1'b1;
        cyc(8);
        check(oe, 4'h2);
        rd_byte(8'h3C);
        check(tr_s, 1'b1);
        wid = sfpc_pkg::SFPC_W_QUAD;
        cyc(2);
        check(oe, 4'hF);
        wid = sfpc_pkg::SFPC_W_DUAL;
        cyc(2);
        check(oe, 4'h3);
        wid = sfpc_pkg::SFPC_W_SINGLE;
        i_host.o_io[3] = 1'b0;
        cyc(6);
        check(pau, 1'b0);
        i_host.o_io[3] = 1'b1;
        wr_sr(6'h01, 1'b0);
        check(st, 6'h01);
        hsel = 1'b1;
        i_host.o_io[3] = 1'b0;
        cyc(6);
        check(pau, 1'b1);
        check(oe, 4'h0);
        check(inr, 1'b0);
        i_host.o_io[3] = 1'b1;
        cyc(6);
        check(sel, 1'b1);
        drv = 1'b0;
        rpin_n = 1'b0;
        cyc(6);
        check(inr, 1'b1);
        check(oe, 4'h0);
        rpin_n = 1'b1;
        i_host.o_cs_n = 1'b1;
        cyc(6);
        check(inr, 1'b0);
        frd = 1'b1;
        rpin_n = 1'b0;
        cyc(6);
        check(inr, 1'b0);
        rpin_n = 1'b1;
        i_host.o_io[3] = 1'b0;
        cyc(6);
        check(inr, 1'b1);
        i_host.o_io[3] = 1'b1;
        cyc(6);
        check(inr, 1'b0);
        repeat (18) i_host.frame(8'h96);
        check(ov_s, 1'b1);
        check(rd, 8'h96);
        rdy = 1'b1;
        cyc(40);
        check(rv, 1'b0);
        print_verdict();
    end
endmodule : sfpc_core_tb_top
